// >>> src/zsd_pkg.sv
// shared constants and carriers of the zero-stuffed down-converter
// assumes a single 250 MHz clock and word-indexed register addresses
package zsd_pkg;

   // ==========================================================
   // widths
   localparam int DATA_W = 16;
   localparam int HDF_W = 24;
   localparam int HDF_STAGES = 5;
   localparam int HDF_GROWTH = 75;
   localparam int LUT_FRAC = 11;
   localparam int SCALE_FRAC = 15;
   localparam int FIR_TAPS = 8;
   localparam int FIR_FRAC = 11;

   // ==========================================================
   // register map (word index)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_DECIM = 4'h1;
   localparam logic [3:0] ADDR_PHASE_INC = 4'h2;
   localparam logic [3:0] ADDR_SCALE = 4'h3;
   localparam logic [3:0] ADDR_SHIFT = 4'h4;
   localparam logic [3:0] ADDR_INTERP = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   localparam logic [3:0] ADDR_OUT_CNT = 4'h7;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_REAL_BIT = 1;
   localparam int STATUS_BAD_BIT = 0;

   // ==========================================================
   // reset values and limits
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [15:0] DECIM_RST = 16'h0010;
   localparam logic [31:0] DECIM_MIN = 32'h0000_0010;
   localparam logic [31:0] DECIM_MAX = 32'h0000_8000;
   localparam logic [31:0] PHASE_INC_RST = 32'h0000_0000;
   localparam logic [15:0] SCALE_RST = 16'h8000;
   localparam logic [6:0] SHIFT_RST = 7'h0C;
   localparam logic [7:0] INTERP_RST = 8'h01;
   localparam logic [2:0] FIR_DEC_QUAD = 3'h4;
   localparam logic [2:0] FIR_DEC_REAL = 3'h2;
   localparam int MIN_DEC_QUAD = 64;
   localparam int MIN_DEC_REAL = 32;
   localparam logic [3:0] QUARTER_TURN = 4'h4;

   // ==========================================================
   // fixed tables
   localparam logic signed [11:0] COS_LUT [16] = '{
      12'h7FF, 12'h763, 12'h5A7, 12'h30F, 12'h000, 12'hCF1, 12'hA59, 12'h89D,
      12'h801, 12'h89D, 12'hA59, 12'hCF1, 12'h000, 12'h30F, 12'h5A7, 12'h763};
   localparam logic signed [11:0] FIR_COEF [FIR_TAPS] = '{
      12'hFE6, 12'h000, 12'h122, 12'h2F8, 12'h2F8, 12'h122, 12'h000, 12'hFE6};

   // ==========================================================
   // types
   typedef enum {ROT_0, ROT_1, ROT_2, ROT_3} zsd_rot_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } zsd_reg_req_s;

   typedef struct packed {
      logic valid;
      logic signed [HDF_W-1:0] i;
      logic signed [HDF_W-1:0] q;
   } zsd_out_s;

endpackage

// >>> src/zsd_hdf.sv
// five-stage integrate-and-comb decimator with programmable rate
// assumes one input per clock and a stable rate while running
`timescale 1ns/10ps
module zsd_hdf
   import zsd_pkg::*;
#(
   parameter int IN_W = DATA_W,
   parameter int OUT_W = HDF_W,
   parameter int ACC_W = DATA_W + HDF_GROWTH
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic signed [IN_W-1:0] din,
   input wire logic [15:0] rate_m1,
   input wire logic [6:0] shift,
   output logic signed [OUT_W-1:0] dout,
   output logic dout_valid
);

   // ==========================================================
   // decimation counter
   logic [15:0] cnt_reg, cnt_next;
   logic tick;
   assign tick = (cnt_reg == 16'h0000);

   always_comb
   begin
      cnt_next = tick ? rate_m1 : cnt_reg - 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_reg <= 16'h0000;
      else
         cnt_reg <= cnt_next;
   end

   // ==========================================================
   // integrators at full rate, combs at decimated rate
   // wrap-around arithmetic is harmless: combs undo it
   logic signed [ACC_W-1:0] integ_reg [HDF_STAGES];
   logic signed [ACC_W-1:0] comb_reg [HDF_STAGES];
   logic signed [ACC_W-1:0] dly_reg [HDF_STAGES];

   genvar s;
   generate
      for (s = 0; s < HDF_STAGES; s++)
      begin : g_stage
         logic signed [ACC_W-1:0] integ_next, comb_next, dly_next, x;
         always_comb
         begin
            // guarded index keeps stage 0 from naming an element below the array
            integ_next = integ_reg[s] + ((s == 0) ? ACC_W'(din) : integ_reg[(s == 0) ? 0 : s-1]);
            x = (s == 0) ? integ_reg[HDF_STAGES-1] : comb_reg[(s == 0) ? 0 : s-1];
            dly_next = tick ? x : dly_reg[s];
            comb_next = tick ? x - dly_reg[s] : comb_reg[s];
         end
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               integ_reg[s] <= '0;
               dly_reg[s] <= '0;
               comb_reg[s] <= '0;
            end
            else
            begin
               integ_reg[s] <= integ_next;
               dly_reg[s] <= dly_next;
               comb_reg[s] <= comb_next;
            end
         end
      end
   endgenerate

   // ==========================================================
   // output alignment by programmed data shift
   logic signed [OUT_W-1:0] dout_next;
   logic valid_next;
   logic signed [ACC_W-1:0] shifted;

   always_comb
   begin
      shifted = comb_reg[HDF_STAGES-1] >>> shift;
      dout_next = tick ? shifted[OUT_W-1:0] : dout;
      valid_next = tick;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         dout <= '0;
         dout_valid <= 1'b0;
      end
      else
      begin
         dout <= dout_next;
         dout_valid <= valid_next;
      end
   end

endmodule

// >>> src/zsd_top.sv
// down-converter fed by an external zero-stuffing expander
// assumes sample_in is synchronous to clk and valid on every clock
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps

// What this block does
// - each high-decimation filter takes a decimation factor from 16 to 32768
// - quadrature format: shaping FIR decimates by 4 on its own
// - real format: shaping FIRs decimate by 2 on their own
// - real format: rotate FIR pair by quarter output rate, sum to one stream
// - quadrature format: overall decimation at least 64 without expander
// - real format: overall decimation at least 32 without expander
// - mixer moves band centre to DC, each product feeds its own filter
// - each high-decimation output is scaled by a gain factor before the FIR
// - filtering after zero stuffing applies a gain of L
module zsd_top
   import zsd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire zsd_reg_req_s reg_req,
   output logic [31:0] reg_rdata,
   input wire logic signed [DATA_W-1:0] sample_in,
   output zsd_out_s out
);

   // ==========================================================
   // register file
   logic [1:0] ctrl_reg, ctrl_next;
   logic [15:0] decim_reg, decim_next;
   logic [31:0] phase_inc_reg, phase_inc_next;
   logic [15:0] scale_reg, scale_next;
   logic [6:0] shift_reg, shift_next;
   logic [7:0] interp_reg, interp_next;
   logic bad_reg, bad_next;
   logic [31:0] out_cnt_reg, out_cnt_next;
   logic [31:0] rdata_next;
   logic real_mode, path_rst, rate_ok;

   assign real_mode = ctrl_reg[CTRL_REAL_BIT];
   assign path_rst = srst | ~ctrl_reg[CTRL_EN_BIT];
   assign rate_ok = (reg_req.wdata >= DECIM_MIN) && (reg_req.wdata <= DECIM_MAX);

   always_comb
   begin
      ctrl_next = ctrl_reg;
      decim_next = decim_reg;
      phase_inc_next = phase_inc_reg;
      scale_next = scale_reg;
      shift_next = shift_reg;
      interp_next = interp_reg;
      bad_next = bad_reg;
      out_cnt_next = out.valid ? out_cnt_reg + 32'h0000_0001 : out_cnt_reg;
      rdata_next = 32'h0000_0000;
      if (reg_req.wr)
      begin
         case (reg_req.addr)
            ADDR_CTRL: ctrl_next = reg_req.wdata[1:0];
            ADDR_DECIM:
            begin
               // out-of-range factor is refused and flagged
               if (rate_ok)
                  decim_next = reg_req.wdata[15:0];
               else
                  bad_next = 1'b1;
            end
            ADDR_PHASE_INC: phase_inc_next = reg_req.wdata;
            ADDR_SCALE: scale_next = reg_req.wdata[15:0];
            ADDR_SHIFT: shift_next = reg_req.wdata[6:0];
            ADDR_INTERP: interp_next = reg_req.wdata[7:0];
            ADDR_STATUS:
            begin
               if (reg_req.wdata[STATUS_BAD_BIT])
                  bad_next = 1'b0;
            end
            default: ;
         endcase
      end
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            ADDR_CTRL: rdata_next = {30'h0000_0000, ctrl_reg};
            ADDR_DECIM: rdata_next = {16'h0000, decim_reg};
            ADDR_PHASE_INC: rdata_next = phase_inc_reg;
            ADDR_SCALE: rdata_next = {16'h0000, scale_reg};
            ADDR_SHIFT: rdata_next = {25'h000_0000, shift_reg};
            ADDR_INTERP: rdata_next = {24'h00_0000, interp_reg};
            ADDR_STATUS: rdata_next = {31'h0000_0000, bad_reg};
            ADDR_OUT_CNT: rdata_next = out_cnt_reg;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_reg <= CTRL_RST;
         decim_reg <= DECIM_RST;
         phase_inc_reg <= PHASE_INC_RST;
         scale_reg <= SCALE_RST;
         shift_reg <= SHIFT_RST;
         interp_reg <= INTERP_RST;
         bad_reg <= 1'b0;
         out_cnt_reg <= 32'h0000_0000;
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         decim_reg <= decim_next;
         phase_inc_reg <= phase_inc_next;
         scale_reg <= scale_next;
         shift_reg <= shift_next;
         interp_reg <= interp_next;
         bad_reg <= bad_next;
         out_cnt_reg <= out_cnt_next;
         reg_rdata <= rdata_next;
      end
   end

   a_rate_range: assert property (@(posedge clk) disable iff (srst)
      32'(decim_reg) >= DECIM_MIN && 32'(decim_reg) <= DECIM_MAX)
      else $error("decimation factor out of range");

   a_bad_rate_refused: assert property (@(posedge clk) disable iff (srst)
      reg_req.wr && reg_req.addr == ADDR_DECIM && !rate_ok |=> bad_reg && $stable(decim_reg))
      else $error("bad factor not refused");

   // ==========================================================
   // quadrature mixer; input taken every clock, stuffed zeros included
   logic [31:0] phase_reg, phase_next;
   logic signed [DATA_W-1:0] mix_reg [2];
   logic signed [DATA_W-1:0] mix_next [2];
   logic signed [DATA_W+11:0] prod_c, prod_s;
   logic [3:0] lut_idx;

   always_comb
   begin
      phase_next = phase_reg + phase_inc_reg;
      lut_idx = phase_reg[31:28];
      prod_c = sample_in * COS_LUT[lut_idx];
      prod_s = sample_in * COS_LUT[lut_idx - QUARTER_TURN];
      // multiply by exp(-jwt) to bring the band centre to DC
      mix_next[0] = prod_c[DATA_W-1+LUT_FRAC:LUT_FRAC];
      mix_next[1] = -prod_s[DATA_W-1+LUT_FRAC:LUT_FRAC];
   end

   always_ff @(posedge clk)
   begin
      if (path_rst)
      begin
         phase_reg <= 32'h0000_0000;
         mix_reg[0] <= '0;
         mix_reg[1] <= '0;
      end
      else
      begin
         phase_reg <= phase_next;
         mix_reg[0] <= mix_next[0];
         mix_reg[1] <= mix_next[1];
      end
   end

   a_zero_stays_zero: assert property (@(posedge clk) disable iff (path_rst)
      sample_in == '0 |=> mix_reg[0] == '0 && mix_reg[1] == '0)
      else $error("stuffed zero not kept at zero");

   // ==========================================================
   // shared pacing of gain and shaping FIR
   logic gain_v_reg, gain_v_next;
   logic fir_v_reg, fir_v_next;
   logic [2:0] fir_cnt_reg, fir_cnt_next;
   logic [2:0] fir_dec;
   logic fire;
   logic hdf_v [2];

   assign fir_dec = real_mode ? FIR_DEC_REAL : FIR_DEC_QUAD;
   assign fire = gain_v_reg && (fir_cnt_reg == fir_dec - 3'h1);

   always_comb
   begin
      gain_v_next = hdf_v[0];
      fir_v_next = fire;
      fir_cnt_next = fir_cnt_reg;
      if (gain_v_reg)
         fir_cnt_next = fire ? 3'h0 : fir_cnt_reg + 3'h1;
   end

   always_ff @(posedge clk)
   begin
      if (path_rst)
      begin
         gain_v_reg <= 1'b0;
         fir_v_reg <= 1'b0;
         fir_cnt_reg <= 3'h0;
      end
      else
      begin
         gain_v_reg <= gain_v_next;
         fir_v_reg <= fir_v_next;
         fir_cnt_reg <= fir_cnt_next;
      end
   end

   a_quad_by_four: assert property (@(posedge clk) disable iff (path_rst)
      !real_mode && gain_v_reg && fir_cnt_reg == 3'h3 |=> fir_v_reg)
      else $error("quadrature FIR did not decimate by four");

   a_real_by_two: assert property (@(posedge clk) disable iff (path_rst)
      real_mode && gain_v_reg && fir_cnt_reg == 3'h1 |=> fir_v_reg)
      else $error("real FIR did not decimate by two");

   // ==========================================================
   // per path: high-decimation filter, gain, shaping FIR
   logic signed [HDF_W-1:0] hdf_d [2];
   logic signed [HDF_W-1:0] gain_reg [2];
   logic signed [HDF_W-1:0] fir_reg [2];

   // scale is 1.15 unsigned; L restores amplitude lost to the stuffed zeros
   function automatic logic signed [HDF_W-1:0] gain_apply(input logic signed [HDF_W-1:0] x,
                                                          input logic [15:0] sc, input logic [7:0] l);
      logic signed [HDF_W+16:0] scaled;
      logic signed [HDF_W+8:0] lgain;
      scaled = x * $signed({1'b0, sc});
      lgain = scaled[HDF_W-1+SCALE_FRAC:SCALE_FRAC] * $signed({1'b0, l});
      return lgain[HDF_W-1:0];
   endfunction

   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_path
         logic signed [HDF_W-1:0] tap_reg [FIR_TAPS-1];
         logic signed [HDF_W-1:0] tap_next [FIR_TAPS-1];
         logic signed [HDF_W-1:0] gain_next, fir_next;
         logic signed [HDF_W+14:0] sum;

         zsd_hdf u_hdf (
            .clk(clk),
            .srst(path_rst),
            .din(mix_reg[p]),
            .rate_m1(decim_reg - 16'h0001),
            .shift(shift_reg),
            .dout(hdf_d[p]),
            .dout_valid(hdf_v[p])
         );

         always_comb
         begin
            gain_next = hdf_v[p] ? gain_apply(hdf_d[p], scale_reg, interp_reg) : gain_reg[p];
            sum = (HDF_W+15)'(gain_reg[p] * FIR_COEF[0]);
            for (int k = 1; k < FIR_TAPS; k++)
               sum = sum + (HDF_W+15)'(tap_reg[k-1] * FIR_COEF[k]);
            fir_next = fire ? sum[HDF_W-1+FIR_FRAC:FIR_FRAC] : fir_reg[p];
            for (int k = 0; k < FIR_TAPS-1; k++)
               tap_next[k] = tap_reg[k];
            if (gain_v_reg)
            begin
               tap_next[0] = gain_reg[p];
               for (int k = 1; k < FIR_TAPS-1; k++)
                  tap_next[k] = tap_reg[k-1];
            end
         end

         always_ff @(posedge clk)
         begin
            if (path_rst)
            begin
               gain_reg[p] <= '0;
               fir_reg[p] <= '0;
               for (int k = 0; k < FIR_TAPS-1; k++)
                  tap_reg[k] <= '0;
            end
            else
            begin
               gain_reg[p] <= gain_next;
               fir_reg[p] <= fir_next;
               for (int k = 0; k < FIR_TAPS-1; k++)
                  tap_reg[k] <= tap_next[k];
            end
         end
      end
   endgenerate

   a_gain_applied: assert property (@(posedge clk) disable iff (path_rst)
      hdf_v[0] |=> gain_v_reg && gain_reg[0] == gain_apply($past(hdf_d[0]), scale_reg, interp_reg))
      else $error("filter output not gain scaled");

   // ==========================================================
   // output: quadrature pair or quarter-rate rotated real stream
   zsd_rot_e rot_reg, rot_next;
   zsd_out_s out_next;

   always_comb
   begin
      rot_next = rot_reg;
      out_next = out;
      out_next.valid = fir_v_reg;
      if (fir_v_reg)
      begin
         if (real_mode)
         begin
            // i*cos - q*sin with cos, sin in {1, 0, -1, 0}
            out_next.q = '0;
            case (rot_reg)
               ROT_0: begin out_next.i = fir_reg[0]; rot_next = ROT_1; end
               ROT_1: begin out_next.i = -fir_reg[1]; rot_next = ROT_2; end
               ROT_2: begin out_next.i = -fir_reg[0]; rot_next = ROT_3; end
               ROT_3: begin out_next.i = fir_reg[1]; rot_next = ROT_0; end
               default: begin out_next.i = fir_reg[0]; rot_next = ROT_0; end
            endcase
         end
         else
         begin
            out_next.i = fir_reg[0];
            out_next.q = fir_reg[1];
            rot_next = ROT_0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (path_rst)
      begin
         rot_reg <= ROT_0;
         out <= '0;
      end
      else
      begin
         rot_reg <= rot_next;
         out <= out_next;
      end
   end

   a_real_q_zero: assert property (@(posedge clk) disable iff (path_rst)
      out.valid && $past(real_mode) |-> out.q == '0)
      else $error("real stream has quadrature part");

   a_real_rotate: assert property (@(posedge clk) disable iff (path_rst)
      fir_v_reg && real_mode && rot_reg == ROT_1 |=> out.valid && out.i == -$past(fir_reg[1]))
      else $error("quarter-rate rotation wrong");

   // ==========================================================
   // output spacing checks; only meaningful between writes
   logic [15:0] gap_reg;
   logic seen_reg;

   always_ff @(posedge clk)
   begin
      if (path_rst || reg_req.wr)
      begin
         gap_reg <= 16'h0000;
         seen_reg <= 1'b0;
      end
      else
      begin
         seen_reg <= seen_reg | out.valid;
         gap_reg <= out.valid ? 16'h0000 : (gap_reg == 16'hFFFF ? gap_reg : gap_reg + 16'h0001);
      end
   end

   a_quad_spacing: assert property (@(posedge clk) disable iff (path_rst)
      out.valid && seen_reg && !real_mode |-> 32'(gap_reg) + 1 >= MIN_DEC_QUAD)
      else $error("quadrature decimation below minimum");

   a_real_spacing: assert property (@(posedge clk) disable iff (path_rst)
      out.valid && seen_reg && real_mode |-> 32'(gap_reg) + 1 >= MIN_DEC_REAL)
      else $error("real decimation below minimum");

endmodule

// >>> tb/zsd_exp_model.sv
// zero-stuffing expander model feeding the down-converter sample port
// assumes the source holds one sample per L-cycle slot and L is at least 1
`timescale 1ns/10ps
module zsd_exp_model
   import zsd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] l_factor,
   input wire logic signed [DATA_W-1:0] src_data,
   output logic signed [DATA_W-1:0] sample_out
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;

   // ==========================================================
   // divide-by-L counter, phase pinned by reset so stuffing stays periodic
   always_comb
   begin
      cnt_next = (cnt_reg + 8'h01 >= l_factor) ? 8'h00 : cnt_reg + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_reg <= 8'h00;
      else
         cnt_reg <= cnt_next;
   end

   // ==========================================================
   // one source sample per slot, gated to zero elsewhere: rate is clock over L
   assign sample_out = (cnt_reg == 8'h00) ? src_data : '0;
endmodule

// >>> tb/zsd_top_tb.sv
// self-checking bench for the zero-stuffed down-converter
// assumes a 250 MHz clock and the expander model on the sample port
`timescale 1ns/10ps
module zsd_top_tb
   import zsd_pkg::*;
;
   logic clk;
   logic srst;
   logic exp_srst;
   zsd_reg_req_s reg_req;
   logic [31:0] reg_rdata;
   logic signed [DATA_W-1:0] sample_in;
   logic signed [DATA_W-1:0] src_data;
   logic [7:0] l_factor;
   zsd_out_s out;
   int n_errors;
   int total_checks;
   logic signed [HDF_W-1:0] cap_i [4];
   logic signed [HDF_W-1:0] cap_q [4];
   logic signed [HDF_W-1:0] ref_i;
   int cap_gap;

   zsd_top dut (.clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .sample_in(sample_in), .out(out));
   zsd_exp_model partner (.clk(clk), .srst(exp_srst), .l_factor(l_factor),
      .src_data(src_data), .sample_out(sample_in));

   // ==========================================================
   // shared tasks
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge clk);
      reg_req.wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge clk);
      reg_req.rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // skips fill outputs, keeps four steady ones and the last spacing
   task automatic run_stream(input logic [31:0] ctrl, input logic [7:0] l, input logic [31:0] scale);
      int n;
      int k;
      int t_last;
      reg_wr(ADDR_CTRL, 32'h0);
      reg_wr(ADDR_INTERP, {24'h0, l});
      reg_wr(ADDR_SCALE, scale);
      l_factor <= l;
      exp_srst <= 1'b1;
      @(posedge clk);
      exp_srst <= 1'b0;
      reg_wr(ADDR_CTRL, ctrl);
      k = 0;
      n = 0;
      t_last = 0;
      while (k < 12 && n < 8000)
      begin
         @(posedge clk);
         #1;
         n++;
         if (out.valid === 1'b1)
         begin
            if (k >= 8)
            begin
               cap_i[k-8] = out.i;
               cap_q[k-8] = out.q;
            end
            cap_gap = n - t_last;
            t_last = n;
            k++;
         end
      end
      if (k < 12)
      begin
         n_errors++;
         end_sim();
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset_vals();
      logic [31:0] d;
      logic [31:0] exp_v [9] = '{32'h0, 32'h10, 32'h0, 32'h8000, 32'hC, 32'h1, 32'h0, 32'h0, 32'h0};
      for (int k = 0; k < 9; k++)
      begin
         reg_rd(k[3:0], d);
         check(d, exp_v[k]);
      end
      @(posedge clk);
      #1;
      check(reg_rdata, 32'h0);
   endtask

   task automatic t_decim_limits();
      logic [31:0] d;
      logic [31:0] wv [4] = '{32'h8000, 32'h8001, 32'h10, 32'hF};
      logic [31:0] dv [4] = '{32'h8000, 32'h8000, 32'h10, 32'h10};
      for (int k = 0; k < 4; k++)
      begin
         reg_wr(ADDR_DECIM, wv[k]);
         reg_rd(ADDR_DECIM, d);
         check(d, dv[k]);
         reg_rd(ADDR_STATUS, d);
         check(d, {31'h0, k[0]});
         reg_wr(ADDR_STATUS, 32'h1);
      end
      reg_rd(ADDR_STATUS, d);
      check(d, 32'h0);
   endtask

   task automatic t_quad();
      run_stream(32'h1, 8'h01, 32'h8000);
      check(cap_gap, 32'd64);
      check({8'h0, cap_q[3]}, 32'h0);
      check({31'h0, cap_i[3] > 0}, 32'h1);
      check({8'h0, cap_i[2]}, {8'h0, cap_i[3]});
      ref_i = cap_i[3];
   endtask

   task automatic t_interp_gain();
      // half the samples are stuffed zeros; a gain of two restores the level
      run_stream(32'h1, 8'h02, 32'h8000);
      check(cap_gap, 32'd64);
      check({8'h0, cap_i[3]}, {8'h0, ref_i});
      check({8'h0, cap_q[3]}, 32'h0);
   endtask

   task automatic t_scale();
      run_stream(32'h1, 8'h01, 32'h4000);
      check({8'h0, cap_i[3]}, {8'h0, ref_i >>> 1});
   endtask

   task automatic t_real();
      logic signed [HDF_W-1:0] nz;
      logic [31:0] d;
      run_stream(32'h3, 8'h01, 32'h8000);
      check(cap_gap, 32'd32);
      check({8'h0, cap_i[0] + cap_i[2]}, 32'h0);
      check({8'h0, cap_i[1] + cap_i[3]}, 32'h0);
      check({31'h0, cap_i[0] == 0 || cap_i[1] == 0}, 32'h1);
      nz = cap_i[0] | cap_i[1];
      check({31'h0, nz == ref_i || nz == -ref_i}, 32'h1);
      check({8'h0, cap_q[3]}, 32'h0);
      // four streams of twelve outputs each since reset
      reg_rd(ADDR_OUT_CNT, d);
      check(d, 32'd48);
   endtask

   // ==========================================================
   // clock, reset and main sequence
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial
   begin
      n_errors = 0;
      total_checks = 0;
      srst = 1'b1;
      exp_srst = 1'b1;
      reg_req = '0;
      src_data = 16'sh0010;
      l_factor = 8'h01;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      exp_srst <= 1'b0;
      t_reset_vals();
      t_decim_limits();
      t_quad();
      t_interp_gain();
      t_scale();
      t_real();
      end_sim();
   end
endmodule
